// ==== src/piw_irq_ctrl.sv ====
// Purpose: Priority encoder, vector source and watchdog for the processor board.
// Assumes: All pins but clock and reset_n are asynchronous and pass two flip-flops first.
// Notes: Vector low nibble is driven only during acknowledge.
`timescale 1ns/1ps
`include "piw_defs.svh"
// Behaviour
// R1: Watchdog counts the 450 Hz timebase and raises its request from the count.
// R2: Request rises 1.14 s after the latest clear; each clear zeroes the count.
// R3: Software must clear the watchdog more often than every 1.14 s.
// R4: Clear pulse comes only from a processor clear command, never autonomously.
// R5: Static disable input keeps the watchdog request low at all times.
// R6: Sample requests and gate lines; drive highest pending level continuously.
// R7: Level drives three active-low lines in binary; all high means none.
// R8: On acknowledge, return vector of the highest pending request.
// R9: Drive only the low four vector bits; upper four float high.
// R10: Watchdog level 6 F4, keypad 3 FA, power fail 2 FB; level 7 unused.
// R11: Serial sources level 5 F6 F7 F8; calendar, GPIB level 4 F5 F9; others FF.
// R12: Two gate lines from the serial controller enable certain sources.
// R13: Fan fault is asserted when low and idle when high.
// R14: Equal-level ties go to the source listed first at that level.
// R15: A gated-off source takes no part in level or vector.
module piw_irq_ctrl (
	input wire logic clock, // Core clock, 200 MHz.
	input wire logic reset_n, // Synchronous reset, active low.
	input wire logic timebase_450hz, // Watchdog timebase pin.
	input wire logic watchdog_clear_select, // Processor clear command strobe.
	input wire logic watchdog_disable_strap, // Watchdog disable, high disables.
	input wire logic irq_gate_line_1, // Gate for the external serial source.
	input wire logic irq_gate_line_2, // Gate for the calendar source.
	input wire logic rear_serial_irq_n, // Rear serial request.
	input wire logic guard_serial_irq_n, // Guard-crossing serial request.
	input wire logic external_serial_irq_n, // External serial request.
	input wire logic calendar_irq_n, // Calendar request.
	input wire logic rear_gpib_irq_n, // Bus interface request.
	input wire logic keypad_irq_n, // Keypad request.
	input wire logic power_fail_irq_n, // Power-fail request.
	input wire logic fan_fault_n, // Fan fault, low is fault.
	input wire logic nvm_ready_busy, // Memory ready/busy.
	input wire logic iack, // Interrupt acknowledge cycle active.
	output logic cpu_level_bit0_n, // Level bit 0, active low.
	output logic cpu_level_bit1_n, // Level bit 1, active low.
	output logic cpu_level_bit2_n, // Level bit 2, active low.
	output logic [3:0] vector_low_o, // Vector low nibble.
	output logic [3:0] vector_low_oe, // Nibble drive enable.
	output logic watchdog_clear_pulse, // Clear pulse to the counter.
	output logic watchdog_irq, // Watchdog request.
	output logic fan_fault // Fan fault seen, active high.
);
	// Width of the synchroniser and the place of each pin inside it.
	localparam int NIN = 15;
	localparam int P_TICK = 14;
	localparam int P_CLR = 13;
	localparam int P_STRAP = 12;
	localparam int P_GATE1 = 11;
	localparam int P_GATE2 = 10;
	localparam int P_REAR = 9;
	localparam int P_GUARD = 8;
	localparam int P_EXT = 7;
	localparam int P_CAL = 6;
	localparam int P_GPIB = 5;
	localparam int P_KEY = 4;
	localparam int P_PWR = 3;
	localparam int P_FAN = 2;
	localparam int P_NVM = 1;
	localparam int P_IACK = 0;

	logic [NIN-1:0] meta_ff;
	logic [NIN-1:0] sync_ff;
	logic tick_d_ff;
	logic [2:0] level_n_ff;
	logic [3:0] vec_ff;
	logic [3:0] oe_ff;
	logic clr_ff;
	logic fan_ff;
	logic wd_irq;
	piw_pkg::piw_req_t req;
	piw_pkg::piw_sel_t sel;

	// Fixed order: the first source listed at a level wins a tie.
	function automatic piw_pkg::piw_sel_t pick(input piw_pkg::piw_req_t r);
		piw_pkg::piw_sel_t s;
		s.level = `PIW_LVL_NONE;
		s.vector = `PIW_VEC_NONE;
		if (r.watchdog) begin
			s = '{`PIW_LVL_WDOG, `PIW_VEC_WDOG}; // R10
		end else if (r.rear_serial) begin
			s = '{`PIW_LVL_SER, `PIW_VEC_REAR}; // R11 R14
		end else if (r.guard_serial) begin
			s = '{`PIW_LVL_SER, `PIW_VEC_GUARD}; // R11
		end else if (r.external_serial) begin
			s = '{`PIW_LVL_SER, `PIW_VEC_EXT}; // R11
		end else if (r.calendar) begin
			s = '{`PIW_LVL_CAL, `PIW_VEC_CAL}; // R11 R14
		end else if (r.rear_gpib) begin
			s = '{`PIW_LVL_CAL, `PIW_VEC_GPIB}; // R11
		end else if (r.keypad) begin
			s = '{`PIW_LVL_KEY, `PIW_VEC_KEY}; // R10
		end else if (r.power_fail) begin
			s = '{`PIW_LVL_PWR, `PIW_VEC_PWR}; // R10
		end
		return s;
	endfunction

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			// Quiet levels, so that leaving reset shows no false edge, clear or acknowledge.
			meta_ff <= `PIW_SYNC_IDLE;
		end else begin
			meta_ff[P_TICK] <= timebase_450hz;
			meta_ff[P_CLR] <= watchdog_clear_select; // R4
			meta_ff[P_STRAP] <= watchdog_disable_strap; // R5
			meta_ff[P_GATE1] <= irq_gate_line_1; // R12
			meta_ff[P_GATE2] <= irq_gate_line_2; // R12
			meta_ff[P_REAR] <= rear_serial_irq_n; // R6
			meta_ff[P_GUARD] <= guard_serial_irq_n; // R6
			meta_ff[P_EXT] <= external_serial_irq_n; // R6
			meta_ff[P_CAL] <= calendar_irq_n; // R6
			meta_ff[P_GPIB] <= rear_gpib_irq_n; // R6
			meta_ff[P_KEY] <= keypad_irq_n; // R6
			meta_ff[P_PWR] <= power_fail_irq_n; // R6
			meta_ff[P_FAN] <= fan_fault_n; // R13
			// Ready/busy is carried along but never raises a request.
			meta_ff[P_NVM] <= nvm_ready_busy;
			meta_ff[P_IACK] <= iack; // R8
		end
	end

	// Second stage; only this stage feeds any logic.
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			sync_ff <= `PIW_SYNC_IDLE;
		end else begin
			sync_ff <= meta_ff;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			tick_d_ff <= 1'b0;
		end else begin
			tick_d_ff <= sync_ff[P_TICK];
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			clr_ff <= 1'b0;
		end else begin
			// One pulse for every cycle the processor command is seen, never otherwise.
			clr_ff <= sync_ff[P_CLR]; // R4
		end
	end

	// Each rising edge of the timebase gives the counter one step while the watchdog request is low.
	piw_watchdog u_watchdog (
		.clock(clock),
		.reset_n(reset_n),
		.tick_edge(sync_ff[P_TICK] && !tick_d_ff),
		.clear_pulse(clr_ff),
		.disable_strap(sync_ff[P_STRAP]),
		.irq(wd_irq)
	);

	always_comb begin
		req.watchdog = wd_irq;
		req.rear_serial = !sync_ff[P_REAR];
		req.guard_serial = !sync_ff[P_GUARD];
		// Gated sources drop out of level and vector alike.
		req.external_serial = !sync_ff[P_EXT] && sync_ff[P_GATE1]; // R12 R15
		req.calendar = !sync_ff[P_CAL] && sync_ff[P_GATE2]; // R12 R15
		req.rear_gpib = !sync_ff[P_GPIB];
		req.keypad = !sync_ff[P_KEY];
		req.power_fail = !sync_ff[P_PWR];

		sel = pick(req); // R8
	end

	// The level lines are held inverted so that each output is a flip-flop.
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			level_n_ff <= ~`PIW_LVL_NONE;
		end else begin
			level_n_ff <= ~sel.level; // R6 R7
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			vec_ff <= 4'hf;
		end else begin
			vec_ff <= sel.vector[3:0]; // R8 R9
		end
	end

	// Only the low nibble is ever driven; the upper one rests on pull-ups.
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			oe_ff <= 4'h0;
		end else begin
			oe_ff <= {4{sync_ff[P_IACK]}}; // R9
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			fan_ff <= 1'b0;
		end else begin
			// The fan input is reported only; it raises no request.
			fan_ff <= !sync_ff[P_FAN]; // R13
		end
	end

	// Every output below is the plain value of a flip-flop.
	assign cpu_level_bit0_n = level_n_ff[0]; // R7
	assign cpu_level_bit1_n = level_n_ff[1]; // R7
	assign cpu_level_bit2_n = level_n_ff[2]; // R7
	assign vector_low_o = vec_ff;
	assign vector_low_oe = oe_ff;
	assign watchdog_clear_pulse = clr_ff;
	assign watchdog_irq = wd_irq;
	assign fan_fault = fan_ff;
endmodule // piw_irq_ctrl

// ==== src/piw_defs.svh ====
// Purpose: Constants for the priority interrupt controller and its watchdog.
// Assumes: 200 MHz core clock; the 450 Hz timebase arrives as a pin.
// Notes: Vectors are full 8-bit values; only the low nibble is driven.
`ifndef PIW_DEFS_SVH
`define PIW_DEFS_SVH
`define PIW_TICK_HZ 450
`define PIW_TIMEOUT_MS 1140
// Ticks of the timebase until the watchdog request rises.
`define PIW_TIMEOUT_TICKS ((`PIW_TIMEOUT_MS * `PIW_TICK_HZ) / 1000)
`define PIW_CNT_W 10
`define PIW_LVL_WDOG 3'h6
`define PIW_LVL_SER 3'h5
`define PIW_LVL_CAL 3'h4
`define PIW_LVL_KEY 3'h3
`define PIW_LVL_PWR 3'h2
`define PIW_LVL_NONE 3'h0
`define PIW_VEC_WDOG 8'hf4
`define PIW_VEC_CAL 8'hf5
`define PIW_VEC_REAR 8'hf6
`define PIW_VEC_GUARD 8'hf7
`define PIW_VEC_EXT 8'hf8
`define PIW_VEC_GPIB 8'hf9
`define PIW_VEC_KEY 8'hfa
`define PIW_VEC_PWR 8'hfb
`define PIW_VEC_NONE 8'hff
// Synchroniser contents in reset: every pin at its quiet level, strap set, gates shut.
`define PIW_SYNC_IDLE 15'h13fe
`endif

// ==== src/piw_pkg.sv ====
// Purpose: Types for the priority interrupt controller.
// Assumes: Requests are active high inside the package types.
// Notes: None.
package piw_pkg;
	typedef struct packed {
		logic watchdog;
		logic rear_serial;
		logic guard_serial;
		logic external_serial;
		logic calendar;
		logic rear_gpib;
		logic keypad;
		logic power_fail;
	} piw_req_t;
	typedef struct packed {
		logic [2:0] level;
		logic [7:0] vector;
	} piw_sel_t;
endpackage

// ==== src/piw_watchdog.sv ====
// Purpose: Watchdog counter on the 450 Hz timebase.
// Assumes: tick_edge is a one-cycle pulse already synchronised.
// Notes: The request holds once reached until the next clear or until the disable strap is set.
`timescale 1ns/1ps
`include "piw_defs.svh"
module piw_watchdog (
	input wire logic clock, // Core clock.
	input wire logic reset_n, // Synchronous reset, active low.
	input wire logic tick_edge, // One pulse per timebase period.
	input wire logic clear_pulse, // Software clear.
	input wire logic disable_strap, // Static disable.
	output logic irq // Watchdog request.
);
	logic [`PIW_CNT_W-1:0] count_ff;
	logic irq_ff;

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			count_ff <= '0;
		end else if (clear_pulse) begin
			count_ff <= '0; // R2
		end else if (tick_edge && !irq_ff) begin
			count_ff <= count_ff + `PIW_CNT_W'(1); // R1
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			irq_ff <= 1'b0;
		end else if (disable_strap || clear_pulse) begin
			irq_ff <= 1'b0; // R5
		end else if (count_ff >= `PIW_CNT_W'(`PIW_TIMEOUT_TICKS)) begin
			irq_ff <= 1'b1; // R2
		end
	end

	assign irq = irq_ff;
endmodule // piw_watchdog

// ==== verification/piw_host_model.sv ====
// Purpose: Host side of the acknowledge cycle.
// Assumes: The bench raises and holds the request.
// Notes: Undriven low bits read inverted.
`timescale 1ns/1ps
module piw_host_model (
	input wire logic ack_req, // Request.
	input wire logic [3:0] vector_low_o, // Nibble.
	input wire logic [3:0] vector_low_oe, // Enable.
	output logic iack, // Acknowledge.
	output logic [7:0] vector // Vector read.
);
	assign iack = ack_req;
	assign vector = {4'hf, ~(vector_low_o ^ vector_low_oe)};
endmodule // piw_host_model

// ==== verification/piw_irq_ctrl_asserts.sv ====
// Purpose: Port checks on the interrupt controller.
// Assumes: Pins reach the outputs in three edges.
// Notes: Bound to the controller.
`timescale 1ns/1ps
module piw_irq_ctrl_asserts (
	input wire logic clock, // Clock.
	input wire logic reset_n, // Reset.
	input wire logic watchdog_clear_select, // Clear.
	input wire logic watchdog_disable_strap, // Disable.
	input wire logic keypad_irq_n, // Keypad.
	input wire logic fan_fault_n, // Fan pin.
	input wire logic iack, // Acknowledge.
	input wire logic cpu_level_bit0_n, // Level.
	input wire logic cpu_level_bit1_n, // Level.
	input wire logic cpu_level_bit2_n, // Level.
	input wire logic [3:0] vector_low_oe, // Enable.
	input wire logic watchdog_clear_pulse, // Pulse.
	input wire logic watchdog_irq, // Request.
	input wire logic fan_fault // Fan seen.
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	wire [2:0] lvl = ~{cpu_level_bit2_n, cpu_level_bit1_n, cpu_level_bit0_n};
	sequence key_held; (!keypad_irq_n) [*4]; endsequence
	sequence dog_free; (!watchdog_clear_pulse && !watchdog_disable_strap) [*4]; endsequence
	never_seven_a: assert property (lvl != 3'h7) else $error("level 7");
	key_floor_a: assert property (key_held |-> lvl >= 3'h3) else $error("key level");
	oe_active_a: assert property (iack [*4] |-> vector_low_oe == 4'hf) else $error("oe");
	oe_idle_a: assert property ((!iack) [*4] |-> vector_low_oe == 4'h0) else $error("oe");
	clear_cause_a: assert property (
		watchdog_clear_pulse |-> $past(watchdog_clear_select, 3)) else $error("clear");
	strap_quiet_a: assert property (watchdog_disable_strap [*4] |-> !watchdog_irq)
		else $error("strap");
	dog_hold_a: assert property (dog_free ##0 watchdog_irq |=> watchdog_irq)
		else $error("hold");
	fan_sense_a: assert property ((!fan_fault_n) [*4] |-> fan_fault) else $error("fan");
endmodule // piw_irq_ctrl_asserts
bind piw_irq_ctrl piw_irq_ctrl_asserts u_chk (.clock, .reset_n, .watchdog_clear_select,
	.watchdog_disable_strap, .keypad_irq_n, .fan_fault_n, .iack, .cpu_level_bit0_n,
	.cpu_level_bit1_n, .cpu_level_bit2_n, .vector_low_oe, .watchdog_clear_pulse,
	.watchdog_irq, .fan_fault);

// ==== verification/tb_piw_irq_ctrl.sv ====
// Purpose: Self-checking bench for the interrupt controller.
// Assumes: The timebase pin runs fast to keep the run short.
// Notes: Rows hold pins, gates, fan, level and vector.
`timescale 1ns/1ps
module tb_piw_irq_ctrl;
	logic clock, reset_n, tp, clr, strap, g1, g2, fan_n, ack_req, iack, b0, b1, b2, wirq, fan;
	logic cp;
	logic [6:0] rq;
	logic [3:0] vlo, voe;
	logic [7:0] vec;
	int fail_count, n_compared, cyc, pulses;
	wire [2:0] lvl = ~{b2, b1, b0};
	logic [20:0] rows [10] = '{{7'h7f, 3'h7, 3'h0, 8'hff}, {7'h7e, 3'h6, 3'h2, 8'hfb},
		{7'h7c, 3'h7, 3'h3, 8'hfa}, {7'h79, 3'h7, 3'h4, 8'hf9}, {7'h71, 3'h7, 3'h4, 8'hf5},
		{7'h77, 3'h5, 3'h0, 8'hff}, {7'h6f, 3'h3, 3'h0, 8'hff}, {7'h6f, 3'h7, 3'h5, 8'hf8},
		{7'h4f, 3'h7, 3'h5, 8'hf7}, {7'h00, 3'h6, 3'h5, 8'hf6}};
	piw_irq_ctrl dut (.clock, .reset_n, .timebase_450hz(tp), .watchdog_clear_select(clr),
		.watchdog_disable_strap(strap), .irq_gate_line_1(g1), .irq_gate_line_2(g2),
		.rear_serial_irq_n(rq[6]), .guard_serial_irq_n(rq[5]), .external_serial_irq_n(rq[4]),
		.calendar_irq_n(rq[3]), .rear_gpib_irq_n(rq[2]), .keypad_irq_n(rq[1]),
		.power_fail_irq_n(rq[0]), .fan_fault_n(fan_n), .nvm_ready_busy(fan_n), .iack,
		.cpu_level_bit0_n(b0), .cpu_level_bit1_n(b1), .cpu_level_bit2_n(b2), .vector_low_o(vlo),
		.vector_low_oe(voe), .watchdog_clear_pulse(cp), .watchdog_irq(wirq), .fan_fault(fan));
	piw_host_model host (.ack_req, .vector_low_o(vlo), .vector_low_oe(voe), .iack, .vector(vec));
	task automatic tally_and_finish();
		if (fail_count == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge clock) tp <= 1'h1;
			repeat (4) @(posedge clock);
			tp <= 1'h0;
			repeat (3) @(posedge clock);
		end
	endtask
	task automatic wclr();
		@(posedge clock) clr <= 1'h1;
		@(posedge clock) clr <= 1'h0;
		repeat (6) @(posedge clock);
		#1;
	endtask
	initial begin
		clock = 1'h0;
		forever #2.5 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cp === 1'h1) pulses <= pulses + 1;
		if (cyc == 30000) begin
			fail_count++;
			tally_and_finish();
		end
	end
	initial begin
		{tp, clr, strap, ack_req, reset_n} = '0;
		{rq, g1, g2, fan_n} = '1;
		repeat (3) @(posedge clock);
		#1 chk({1'h0, b2, b1, b0, voe}, 8'h70);
		@(posedge clock) reset_n <= 1'h1;
		ack_req <= 1'h1;
		foreach (rows[i]) begin
			@(posedge clock) {rq, g1, g2, fan_n} <= rows[i][20:11];
			repeat (6) @(posedge clock);
			#1 chk({5'h0, lvl}, {5'h0, rows[i][10:8]});
			chk(vec, rows[i][7:0]);
			chk({7'h0, fan}, {7'h0, ~rows[i][11]});
		end
		chk(pulses[7:0], 8'h0);
		wclr();
		chk(pulses[7:0], 8'h1);
		tick(400);
		wclr();
		tick(400);
		#1 chk({7'h0, wirq}, 8'h0);
		wclr();
		tick(512);
		#1 chk({7'h0, wirq}, 8'h0);
		tick(1);
		repeat (4) @(posedge clock);
		#1 chk({7'h0, wirq}, 8'h1);
		chk({5'h0, lvl}, 8'h6);
		chk(vec, 8'hf4);
		wclr();
		chk({7'h0, wirq}, 8'h0);
		@(posedge clock) strap <= 1'h1;
		wclr();
		tick(514);
		#1 chk({7'h0, wirq}, 8'h0);
		@(posedge clock) strap <= 1'h0;
		ack_req <= 1'h0;
		repeat (6) @(posedge clock);
		#1 chk({7'h0, wirq}, 8'h1);
		chk({4'h0, voe}, 8'h0);
		@(posedge clock) reset_n <= 1'h0;
		repeat (4) @(posedge clock);
		#1 chk({1'h0, b2, b1, b0, voe}, 8'h70);
		chk({7'h0, wirq}, 8'h0);
		@(posedge clock) reset_n <= 1'h1;
		repeat (2) @(posedge clock);
		#1 chk({1'h0, b2, b1, b0, voe}, 8'h70);
		repeat (4) @(posedge clock);
		#1 chk({5'h0, lvl}, 8'h5);
		chk(pulses[7:0], 8'h5);
		chk({7'h0, wirq}, 8'h0);
		tally_and_finish();
	end
endmodule // tb_piw_irq_ctrl
